// *** core/nand_pin_interface_decode.v ***
`include "nand_host_defines.vh"
`default_nettype none

module nand_pin_interface_decode #(
  parameter NUM_CS = `NUM_CHIP_SELECTS
) (
  input  wire              clock_in,
  input  wire              reset_n_in,
  // host request side
  input  wire              req_valid_in,
  output wire              req_ready_out,
  input  wire [1:0]        op_code_in,
  input  wire [1:0]        target_cs_in,
  input  wire [7:0]        wr_byte_in,
  input  wire              guard_enable_in,
  output reg  [7:0]        rd_byte_out,
  output reg               rd_valid_out,
  output wire [NUM_CS-1:0] die_ready_out,
  // bus one pins
  output reg               chip_select_1_n_out,
  output reg               chip_select_3_n_out,
  output reg               cmd_latch_1_out,
  output reg               addr_latch_1_out,
  output reg               in_strobe_1_n_out,
  output reg               out_strobe_1_n_out,
  output reg               guard_1_n_out,
  input  wire [7:0]        byte_port_1_in,
  output reg  [7:0]        byte_port_1_out,
  output reg               byte_port_1_oe_out,
  // bus two pins
  output reg               chip_select_2_n_out,
  output reg               chip_select_4_n_out,
  output reg               cmd_latch_2_out,
  output reg               addr_latch_2_out,
  output reg               in_strobe_2_n_out,
  output reg               out_strobe_2_n_out,
  output reg               guard_2_n_out,
  input  wire [7:0]        byte_port_2_in,
  output reg  [7:0]        byte_port_2_out,
  output reg               byte_port_2_oe_out,
  // shared open-drain ready/busy lines, one per select
  input  wire [NUM_CS-1:0] rdy_bsy_n_in
);

  ////////////////////////////////////////////////////////////////////////////
  localparam integer SETUP_INT  = `SETUP_CYC;
  localparam integer PULSE_INT  = `PULSE_CYC;
  localparam integer HOLD_INT   = `HOLD_CYC;
  localparam integer ACCESS_INT = `ACCESS_CYC;
  localparam [2:0]   SETUP_CNT  = SETUP_INT[2:0];
  localparam [2:0]   PULSE_CNT  = PULSE_INT[2:0];
  localparam [2:0]   HOLD_CNT   = HOLD_INT[2:0];
  localparam [2:0]   ACCESS_CNT = ACCESS_INT[2:0];

  wire [NUM_CS-1:0] rdy_sync;
  wire [7:0]        port_1_sync;
  wire [7:0]        port_2_sync;

  nand_pin_sync #(.WIDTH(NUM_CS + 16)) pin_sync (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   ({rdy_bsy_n_in, byte_port_2_in, byte_port_1_in}),
    .sync_out   ({rdy_sync, port_2_sync, port_1_sync})
  );

  // the line reads high only when every die on it is ready
  assign die_ready_out = rdy_sync;

  ////////////////////////////////////////////////////////////////////////////
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] count_reg;
  reg [2:0] count_next;
  reg [1:0] op_reg;
  reg [1:0] cs_reg;
  reg [7:0] data_reg;

  // odd-numbered selects sit on bus one, even ones on bus two
  wire      on_bus_two = cs_reg[0];
  wire      is_read    = (op_reg == `OP_READ);
  wire      target_rdy = rdy_sync[target_cs_in];

  // a new cycle waits for the synchronised target line to read ready; the two-flop
  // lag lets a die that has just gone busy still be strobed; reads of status while busy are not offered here
  assign req_ready_out = (state_reg == `ST_IDLE) && target_rdy;

  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      `ST_IDLE: begin
        if (req_valid_in && req_ready_out) begin
          state_next = `ST_SETUP;
          count_next = SETUP_CNT;
        end
      end
      `ST_SETUP: begin
        if (count_reg <= 3'h1) begin
          state_next = `ST_PULSE;
          count_next = is_read ? ACCESS_CNT : PULSE_CNT;
        end else begin
          count_next = count_reg - 3'h1;
        end
      end
      `ST_PULSE: begin
        if (count_reg <= 3'h1) begin
          state_next = is_read ? `ST_SAMPLE : `ST_HOLD;
          count_next = HOLD_CNT;
        end else begin
          count_next = count_reg - 3'h1;
        end
      end
      `ST_SAMPLE: begin
        state_next = `ST_HOLD;
        count_next = HOLD_CNT;
      end
      `ST_HOLD: begin
        if (count_reg <= 3'h1) begin
          state_next = `ST_IDLE;
          count_next = 3'h0;
        end else begin
          count_next = count_reg - 3'h1;
        end
      end
      default: begin
        state_next = `ST_IDLE;
        count_next = 3'h0;
      end
    endcase
  end

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= `ST_IDLE;
      count_reg <= 3'h0;
      op_reg    <= `OP_CMD;
      cs_reg    <= 2'h0;
      data_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      if (req_valid_in && req_ready_out) begin
        op_reg   <= op_code_in;
        cs_reg   <= target_cs_in;
        data_reg <= wr_byte_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive; the select goes high in idle between any two cycles of a sequence,
  // even while the request stream keeps coming, so the die may drop to standby
  wire       active    = (state_reg != `ST_IDLE);
  wire       strobe_lo = (state_reg == `ST_PULSE);
  wire       drive     = active && !is_read;
  // only one latch select is ever high; data cycles leave both low
  wire       cle       = active && (op_reg == `OP_CMD);
  wire       ale       = active && (op_reg == `OP_ADDR);
  wire [3:0] cs_hot    = active ? (4'h1 << cs_reg) : 4'h0;

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chip_select_1_n_out <= 1'b1;
      chip_select_2_n_out <= 1'b1;
      chip_select_3_n_out <= 1'b1;
      chip_select_4_n_out <= 1'b1;
      cmd_latch_1_out     <= 1'b0;
      cmd_latch_2_out     <= 1'b0;
      addr_latch_1_out    <= 1'b0;
      addr_latch_2_out    <= 1'b0;
      in_strobe_1_n_out   <= 1'b1;
      in_strobe_2_n_out   <= 1'b1;
      out_strobe_1_n_out  <= 1'b1;
      out_strobe_2_n_out  <= 1'b1;
      guard_1_n_out       <= 1'b0;
      guard_2_n_out       <= 1'b0;
      byte_port_1_out     <= 8'h00;
      byte_port_2_out     <= 8'h00;
      byte_port_1_oe_out  <= 1'b0;
      byte_port_2_oe_out  <= 1'b0;
      rd_byte_out         <= 8'h00;
      rd_valid_out        <= 1'b0;
    end else begin
      // deselect when idle so a ready die can sleep
      chip_select_1_n_out <= !cs_hot[0];
      chip_select_2_n_out <= !cs_hot[1];
      chip_select_3_n_out <= !cs_hot[2];
      chip_select_4_n_out <= !cs_hot[3];
      cmd_latch_1_out     <= cle && !on_bus_two;
      cmd_latch_2_out     <= cle && on_bus_two;
      addr_latch_1_out    <= ale && !on_bus_two;
      addr_latch_2_out    <= ale && on_bus_two;
      // rising edge of the input strobe at the end of pulse takes the byte
      in_strobe_1_n_out   <= !(strobe_lo && !is_read && !on_bus_two);
      in_strobe_2_n_out   <= !(strobe_lo && !is_read && on_bus_two);
      out_strobe_1_n_out  <= !(strobe_lo && is_read && !on_bus_two);
      out_strobe_2_n_out  <= !(strobe_lo && is_read && on_bus_two);
      // guard low from reset until the host lets go; a fall aborts program or erase
      guard_1_n_out       <= guard_enable_in;
      guard_2_n_out       <= guard_enable_in;
      // same eight-bit port for command, address and data
      byte_port_1_out     <= data_reg;
      byte_port_2_out     <= data_reg;
      byte_port_1_oe_out  <= drive && !on_bus_two;
      byte_port_2_oe_out  <= drive && on_bus_two;
      // sample after the access delay plus synchroniser latency
      rd_valid_out        <= (state_reg == `ST_SAMPLE);
      if (state_reg == `ST_SAMPLE) begin
        rd_byte_out <= on_bus_two ? port_2_sync : port_1_sync;
      end
    end
  end

endmodule

`default_nettype wire

// *** core/nand_host_defines.vh ***
`ifndef NAND_HOST_DEFINES_VH
`define NAND_HOST_DEFINES_VH

// host operation codes on op_code_in
`define OP_CMD            2'h0
`define OP_ADDR           2'h1
`define OP_WRITE          2'h2
`define OP_READ           2'h3

// bus control sequencer states
`define ST_IDLE           3'h0
`define ST_SETUP          3'h1
`define ST_PULSE          3'h2
`define ST_HOLD           3'h3
`define ST_SAMPLE         3'h4

// timing in ns at a 25 ns clock
`define CLK_PERIOD_NS     25
`define SETUP_NS          10
`define PULSE_NS          12
`define HOLD_NS           10
`define ACCESS_NS         20
// least times round up to whole cycles, never below one
`define CYC_UP(t)         (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC         `CYC_UP(`SETUP_NS)
`define PULSE_CYC         `CYC_UP(`PULSE_NS)
`define HOLD_CYC          `CYC_UP(`HOLD_NS)
// two extra cycles cover both synchroniser flops ahead of the sample
`define ACCESS_CYC        (`CYC_UP(`ACCESS_NS) + 2)

// device geometry
`define PAGE_BYTES        8568
`define PAGES_PER_BLOCK   128
`define BLOCKS_PER_DIE    4096
`define NUM_CHIP_SELECTS  4

`endif

// *** core/nand_pin_sync.v ***
`default_nettype none

// two flip-flop synchroniser for each bit of a bundle
module nand_pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock_in,
  input  wire             reset_n_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_reg   <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule

`default_nettype wire

// *** verification/nand_die_model.sv ***
`default_nettype none
module nand_die_model (
  input  wire logic       cs_a_n, cs_b_n, cle, ale, we_n, out_strobe_n, wp_n, oe,
  input  wire logic [7:0] din,
  output logic      [7:0] dout,
  output logic            rb_a_n, rb_b_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cmd, col, last;
  logic       ba, bb;
  wire        sel = !cs_a_n || !cs_b_n;
  initial {cmd, col, last, ba, bb} = '0;
  // open drain: a released line reads high through the pull-up
  assign rb_a_n = !ba;
  assign rb_b_n = !bb;
  // a busy die ignores its select and every strobe
  always @(posedge we_n) if (sel && !ba && !bb) begin
    if (cle) cmd = din;
    else if (ale) col = din;
    else col = col + 8'h01;
    if (cle && din == 8'h10 && wp_n) begin
      {ba, bb} = {!cs_a_n, !cs_b_n};
      #300 {ba, bb} = 2'b00;
    end
  end
  always @(negedge wp_n) {ba, bb} = 2'b00;
  always @(negedge out_strobe_n) if (sel && !ba && !bb) begin
    col = col + 8'h01;
    #20 last = col ^ 8'h5A;
  end
  // released port shows the inverse, so a stale byte never passes
  assign dout = (sel && !out_strobe_n && !oe) ? last : ~last;
endmodule
`default_nettype wire

// *** verification/nand_host_asserts.sv ***
`default_nettype none
module nand_host_asserts #(parameter NUM_CS = 4) (
  input wire logic              clock_in, reset_n_in, req_valid_in, req_ready_out,
  input wire logic              guard_enable_in, rd_valid_out,
  input wire logic [1:0]        op_code_in, target_cs_in,
  input wire logic [NUM_CS-1:0] die_ready_out,
  input wire logic              chip_select_1_n_out, chip_select_3_n_out, cmd_latch_1_out,
  input wire logic              addr_latch_1_out, in_strobe_1_n_out, out_strobe_1_n_out,
  input wire logic              byte_port_1_oe_out, guard_1_n_out, guard_2_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  wire take = req_valid_in && req_ready_out;
  ////////////////////////////////////////////////////////////////
  property p_rd_lat; take && op_code_in == 2'h3 |-> ##6 rd_valid_out; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_pulse; rd_valid_out |=> !rd_valid_out; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid too long");
  property p_cmd; take && op_code_in == 2'h0 && target_cs_in == 2'h0 |-> ##[1:3]
    (!chip_select_1_n_out && cmd_latch_1_out && !addr_latch_1_out && !in_strobe_1_n_out);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command cycle wrong");
  property p_addr; take && op_code_in == 2'h1 && target_cs_in == 2'h0 |-> ##[1:3]
    (!chip_select_1_n_out && addr_latch_1_out && !cmd_latch_1_out && !in_strobe_1_n_out);
  endproperty
  a_addr: assert property (p_addr) else $error("address cycle wrong");
  property p_we; $fell(in_strobe_1_n_out) |-> byte_port_1_oe_out ##1 $rose(in_strobe_1_n_out);
  endproperty
  a_we: assert property (p_we) else $error("input strobe pulse wrong");
  property p_re; $fell(out_strobe_1_n_out) |->
    !byte_port_1_oe_out && (!chip_select_1_n_out || !chip_select_3_n_out);
  endproperty
  a_re: assert property (p_re) else $error("output strobe with port driven");
  property p_excl; !(cmd_latch_1_out && addr_latch_1_out); endproperty
  a_excl: assert property (p_excl) else $error("both latch selects high");
  property p_busy; !die_ready_out[target_cs_in] |-> !req_ready_out; endproperty
  a_busy: assert property (p_busy) else $error("request taken while busy");
  property p_guard; !guard_enable_in [*2] |-> !guard_1_n_out && !guard_2_n_out; endproperty
  a_guard: assert property (p_guard) else $error("guard not held low");
endmodule
bind nand_pin_interface_decode nand_host_asserts #(.NUM_CS(NUM_CS)) chk (.clock_in,
  .reset_n_in, .req_valid_in, .req_ready_out, .guard_enable_in, .rd_valid_out, .op_code_in,
  .target_cs_in, .die_ready_out, .chip_select_1_n_out, .chip_select_3_n_out, .cmd_latch_1_out,
  .addr_latch_1_out, .in_strobe_1_n_out, .out_strobe_1_n_out, .byte_port_1_oe_out,
  .guard_1_n_out, .guard_2_n_out);
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_in, reset_n_in, req_valid_in, guard_enable_in, req_ready_out, rd_valid_out;
  logic [1:0]  op_code_in, target_cs_in;
  logic [7:0]  wr_byte_in, rd_byte_out, byte_port_1_in, byte_port_2_in;
  logic [7:0]  byte_port_1_out, byte_port_2_out, col [2];
  logic        byte_port_1_oe_out, byte_port_2_oe_out, guard_1_n_out, guard_2_n_out;
  logic        chip_select_1_n_out, chip_select_2_n_out, chip_select_3_n_out, chip_select_4_n_out;
  logic        cmd_latch_1_out, cmd_latch_2_out, addr_latch_1_out, addr_latch_2_out;
  logic        in_strobe_1_n_out, in_strobe_2_n_out, out_strobe_1_n_out, out_strobe_2_n_out;
  logic [3:0]  die_ready_out;
  wire  [3:0]  rdy_bsy_n_in;
  logic [31:0] seed;
  int          err_count, total_checks;
  nand_pin_interface_decode #(.NUM_CS(4)) uut (.clock_in, .reset_n_in, .req_valid_in,
    .req_ready_out, .op_code_in, .target_cs_in, .wr_byte_in, .guard_enable_in, .rd_byte_out,
    .rd_valid_out, .die_ready_out, .chip_select_1_n_out, .chip_select_3_n_out,
    .cmd_latch_1_out, .addr_latch_1_out, .in_strobe_1_n_out, .out_strobe_1_n_out,
    .guard_1_n_out, .byte_port_1_in, .byte_port_1_out, .byte_port_1_oe_out,
    .chip_select_2_n_out, .chip_select_4_n_out, .cmd_latch_2_out, .addr_latch_2_out,
    .in_strobe_2_n_out, .out_strobe_2_n_out, .guard_2_n_out, .byte_port_2_in,
    .byte_port_2_out, .byte_port_2_oe_out, .rdy_bsy_n_in);
  // selects one and three share bus one, two and four bus two
  nand_die_model bus_one (.cs_a_n(chip_select_1_n_out), .cs_b_n(chip_select_3_n_out),
    .cle(cmd_latch_1_out), .ale(addr_latch_1_out), .we_n(in_strobe_1_n_out),
    .out_strobe_n(out_strobe_1_n_out), .wp_n(guard_1_n_out), .oe(byte_port_1_oe_out),
    .din(byte_port_1_out), .dout(byte_port_1_in), .rb_a_n(rdy_bsy_n_in[0]),
    .rb_b_n(rdy_bsy_n_in[2]));
  nand_die_model bus_two (.cs_a_n(chip_select_2_n_out), .cs_b_n(chip_select_4_n_out),
    .cle(cmd_latch_2_out), .ale(addr_latch_2_out), .we_n(in_strobe_2_n_out),
    .out_strobe_n(out_strobe_2_n_out), .wp_n(guard_2_n_out), .oe(byte_port_2_oe_out),
    .din(byte_port_2_out), .dout(byte_port_2_in), .rb_a_n(rdy_bsy_n_in[1]),
    .rb_b_n(rdy_bsy_n_in[3]));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] c);
    return c ^ 8'h5A;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one request, held until the edge that takes it
  task automatic op(input logic [1:0] c, input logic [1:0] t, input logic [7:0] b);
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    op_code_in <= c;
    target_cs_in <= t;
    wr_byte_in <= b;
    repeat (200) begin
      @(negedge clock_in);
      if (req_ready_out === 1'b1) break;
    end
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    if (c == 2'h1) col[t[0]] = b;
    else if (c != 2'h0) col[t[0]] = col[t[0]] + 8'h01;
    if (c == 2'h3) begin
      repeat (20) begin
        @(negedge clock_in);
        if (rd_valid_out === 1'b1) break;
      end
      check(rd_byte_out, exp_rd(col[t[0]]));
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // the whole run needs well under two thousand cycles
  initial begin
    #(25 * 6000);
    err_count++;
    results();
  end
  initial begin
    {req_valid_in, op_code_in, target_cs_in, wr_byte_in} = '0;
    guard_enable_in = 1'b1;
    {err_count, total_checks} = '0;
    seed = 32'hde36;
    col[0] = 8'h00;
    col[1] = 8'h00;
    reset_n_in = 1'b0;
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    for (int t = 0; t < 4; t++) begin
      op(2'h0, t[1:0], 8'hFF);
      op(2'h0, t[1:0], 8'(rnd()) | 8'h20);
      op(2'h1, t[1:0], 8'(rnd()));
      repeat (1 + rnd() % 3) op(2'h2, t[1:0], 8'(rnd()));
      repeat (2) op(2'h3, t[1:0], 8'h00);
    end
    op(2'h1, 2'h2, 8'hFF);
    op(2'h3, 2'h2, 8'h00);
    op(2'h0, 2'h0, 8'h10);
    repeat (6) @(posedge clock_in);
    #1 check({7'h0, die_ready_out[0]}, 8'h00);
    check({7'h0, req_ready_out}, 8'h00);
    op(2'h3, 2'h0, 8'h00);
    @(posedge clock_in);
    guard_enable_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1 check({6'h0, guard_1_n_out, guard_2_n_out}, 8'h00);
    op(2'h0, 2'h1, 8'h10);
    repeat (6) @(posedge clock_in);
    #1 check({7'h0, die_ready_out[1]}, 8'h01);
    results();
  end
endmodule
`default_nettype wire
